/* File: hdl/tkc_pkg.sv */
package tkc_pkg;
  // command codes
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_SETUP = 8'h01;
  localparam logic [7:0] CMD_CAL_ALL = 8'h03;
  localparam logic [7:0] CMD_LAST = 8'h0f;
  localparam logic [1:0] CMD_CAL_KEY_HI = 2'h3;
  // command field layout
  localparam int KEY_IDX_W = 6;
  localparam int CMD_HI_POS = 6;
  localparam logic [5:0] KEY_MAX = 6'h2f;
  // reply bytes
  localparam logic [7:0] ACK_BYTE = 8'hfe;
  localparam logic [7:0] NAK_BYTE = 8'h00;
  // timing: 100 ms window, 250 MHz clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint WINDOW_MS = 100;
  localparam longint WINDOW_CYC = (WINDOW_MS * 1000000000) / CLK_PERIOD_PS;
  // configuration block length default
  localparam int CFG_LEN_DEF = 16;
endpackage

/* File: hdl/tkc_timer.sv */
// counts down the inter-byte window; restarts on every load pulse
module tkc_timer
  import tkc_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic run,
  input wire logic [CNT_W-1:0] limit,
  output logic expired
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic exp;
  } tkc_tmr_s;

  tkc_tmr_s st;
  tkc_tmr_s next_st;

  // reload on load, count while running, flag at zero
  always_comb
  begin
    next_st = st;
    next_st.exp = 1'b0;
    if (load || !run)
    begin
      next_st.cnt = limit;
    end
    else if (st.cnt == '0)
    begin
      next_st.exp = 1'b1;
      next_st.cnt = limit;
    end
    else
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign expired = st.exp;
endmodule

/* File: hdl/tkc_cmd.sv */
// Contract
// - key recal needs two back-to-back copies within 100ms
// - key recal targets one key, index 0..47
// - recal chosen key in its slot only
// - reply inverse command just before key recal (spi: reply only queued, goes out on a later null byte after the recal strobe)
// - last-command query clears error, resynchronises
// - spi: one null byte pulls one reply
// - config entry halts sensing, takes block plus crc
// - config entry needs two copies within 100ms
// - ack when ready, ack after eeprom write
// - bad crc replaces second ack with zero
// - config bytes each within 100ms else abandon
// - zero crc accepted, check skipped
// - eeprom written even if crc bad, marked invalid
// - invalid eeprom restored from flash on reset
// - sensing restarts after load; host should reset
// - cal-all after double copy, reply, back to run
// - missing second copy: timeout, no reply
// - last-command returns inverse of last byte, clears error
module tkc_cmd
  import tkc_pkg::*;
#(
  parameter longint WINDOW_CYCLES = WINDOW_CYC,
  parameter int CFG_LEN = CFG_LEN_DEF
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spi_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic [15:0] crc_calc,
  input wire logic cal_started,
  input wire logic eeprom_done,
  input wire logic eeprom_invalid_in,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic sensing_halt,
  output logic cal_all_start,
  output logic cal_key_start,
  output logic [5:0] cal_key_idx,
  output logic cfg_wr,
  output logic [7:0] cfg_wr_data,
  output logic crc_clear,
  output logic eeprom_commit,
  output logic eeprom_mark_invalid,
  output logic flash_restore,
  output logic comm_error
);
  localparam int TW = 32;
  localparam logic [TW-1:0] TLIM = TW'(WINDOW_CYCLES - 1);
  localparam logic [15:0] CFG_LEN_L = 16'(CFG_LEN);

  typedef enum logic [2:0] {
    S_IDLE, S_ARMED, S_CAL_WAIT, S_CFG_DATA, S_CFG_CRC, S_CFG_BURN
  } tkc_state_e;

  typedef struct packed {
    tkc_state_e fsm;
    logic [7:0] last_cmd;
    logic [7:0] armed_cmd;
    logic [15:0] byte_cnt;
    logic [15:0] rx_crc;
    logic crc_bad;
    logic [7:0] q_byte;
    logic q_full;
    logic tx_valid;
    logic [7:0] tx_data;
    logic halt;
    logic cal_all;
    logic cal_key;
    logic [5:0] key_idx;
    logic cal_pending_all;
    logic cfg_wr;
    logic [7:0] cfg_data;
    logic crc_clear;
    logic commit;
    logic mark_inv;
    logic restore;
    logic restore_done;
    logic err;
  } tkc_st_s;

  tkc_st_s st;
  tkc_st_s next_st;
  logic tmr_expired;
  logic tmr_run;

  // decide whether a byte is a double-send command
  function automatic logic is_double(input logic [7:0] b);
    is_double = (b == CMD_SETUP) || (b == CMD_CAL_ALL) ||
                (b[7:CMD_HI_POS] == CMD_CAL_KEY_HI);
  endfunction

  // key index valid for a key recal byte
  function automatic logic key_ok(input logic [7:0] b);
    key_ok = b[KEY_IDX_W-1:0] <= KEY_MAX;
  endfunction

  // window runs while waiting for a second copy or config byte
  assign tmr_run = (st.fsm == S_ARMED) || (st.fsm == S_CFG_DATA) ||
                   (st.fsm == S_CFG_CRC);

  tkc_timer #(
    .CNT_W(TW)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(rx_valid),
    .run(tmr_run),
    .limit(TLIM),
    .expired(tmr_expired)
  );

  // reply path: queue one byte, emit now in uart, on null in spi
  function automatic logic emit_now(input logic spi, input logic nul);
    emit_now = !spi || nul;
  endfunction

  always_comb
  begin
    next_st = st;
    next_st.tx_valid = 1'b0;
    next_st.cal_all = 1'b0;
    next_st.cal_key = 1'b0;
    next_st.cfg_wr = 1'b0;
    next_st.crc_clear = 1'b0;
    next_st.commit = 1'b0;
    next_st.mark_inv = 1'b0;
    next_st.restore = 1'b0;
    // one restore pulse after reset when eeprom was invalid
    if (!st.restore_done)
    begin
      next_st.restore_done = 1'b1;
      next_st.restore = eeprom_invalid_in;
    end
    // spi: null byte pulls one queued reply
    if (rx_valid && spi_mode && rx_data == CMD_NULL && st.fsm != S_CFG_DATA &&
        st.fsm != S_CFG_CRC)
    begin
      if (st.q_full)
      begin
        next_st.tx_valid = 1'b1;
        next_st.tx_data = st.q_byte;
        next_st.q_full = 1'b0;
      end
      else
      begin
        next_st.tx_valid = 1'b1;
        next_st.tx_data = 8'h00;
      end
    end
    case (st.fsm)
      S_IDLE, S_ARMED:
      begin
        if (st.fsm == S_ARMED && tmr_expired)
        begin
          next_st.fsm = S_IDLE; // silent timeout
        end
        if (rx_valid && !(spi_mode && rx_data == CMD_NULL))
        begin
          next_st.last_cmd = rx_data;
          next_st.fsm = S_IDLE;
          if (rx_data == CMD_LAST)
          begin
            // inverse of previous byte, clear error
            next_st.q_byte = ~st.last_cmd;
            next_st.q_full = 1'b1;
            next_st.err = 1'b0;
          end
          else if (st.fsm == S_ARMED && rx_data == st.armed_cmd)
          begin
            // second consecutive copy within window
            if (rx_data == CMD_SETUP)
            begin
              next_st.halt = 1'b1;
              next_st.byte_cnt = '0;
              next_st.crc_clear = 1'b1;
              next_st.q_byte = ACK_BYTE; // ready ack
              next_st.q_full = 1'b1;
              next_st.fsm = S_CFG_DATA;
            end
            else if (rx_data == CMD_CAL_ALL)
            begin
              next_st.cal_all = 1'b1;
              next_st.cal_pending_all = 1'b1;
              next_st.fsm = S_CAL_WAIT;
            end
            else
            begin
              // reply first, then strobe key recal
              next_st.q_byte = ~rx_data;
              next_st.q_full = 1'b1;
              next_st.key_idx = rx_data[KEY_IDX_W-1:0];
              next_st.cal_pending_all = 1'b0;
              next_st.fsm = S_CAL_WAIT;
            end
          end
          else if (is_double(rx_data))
          begin
            if (rx_data[7:CMD_HI_POS] == CMD_CAL_KEY_HI && !key_ok(rx_data))
            begin
              next_st.err = 1'b1;
            end
            else
            begin
              next_st.armed_cmd = rx_data;
              next_st.fsm = S_ARMED;
            end
          end
          else
          begin
            next_st.err = 1'b1; // unhandled here: comms error
          end
        end
      end
      S_CAL_WAIT:
      begin
        if (st.cal_pending_all)
        begin
          // ack once calibration has begun, then back to run
          if (cal_started)
          begin
            next_st.q_byte = ~CMD_CAL_ALL;
            next_st.q_full = 1'b1;
            next_st.fsm = S_IDLE;
          end
        end
        else
        begin
          // key slot recal, others keep sensing
          next_st.cal_key = 1'b1;
          next_st.fsm = S_IDLE;
        end
      end
      S_CFG_DATA:
      begin
        if (tmr_expired)
        begin
          next_st.halt = 1'b0; // abandon
          next_st.fsm = S_IDLE;
        end
        else if (rx_valid)
        begin
          next_st.cfg_wr = 1'b1;
          next_st.cfg_data = rx_data;
          next_st.byte_cnt = st.byte_cnt + 16'h0001;
          if (st.byte_cnt == CFG_LEN_L - 16'h0001)
          begin
            next_st.byte_cnt = '0;
            next_st.fsm = S_CFG_CRC;
          end
        end
      end
      S_CFG_CRC:
      begin
        if (tmr_expired)
        begin
          next_st.halt = 1'b0;
          next_st.fsm = S_IDLE;
        end
        else if (rx_valid)
        begin
          // crc arrives low byte first
          if (st.byte_cnt == 16'h0000)
          begin
            next_st.rx_crc[7:0] = rx_data;
            next_st.byte_cnt = 16'h0001;
          end
          else
          begin
            next_st.rx_crc[15:8] = rx_data;
            next_st.crc_bad = ({rx_data, st.rx_crc[7:0]} != 16'h0000) &&
                              ({rx_data, st.rx_crc[7:0]} != crc_calc);
            next_st.commit = 1'b1; // write regardless
            next_st.fsm = S_CFG_BURN;
          end
        end
      end
      S_CFG_BURN:
      begin
        if (eeprom_done)
        begin
          next_st.mark_inv = st.crc_bad;
          next_st.q_byte = st.crc_bad ? NAK_BYTE : ACK_BYTE;
          next_st.q_full = 1'b1;
          next_st.halt = 1'b0; // sensing resumes
          next_st.fsm = S_IDLE;
        end
      end
      default:
      begin
        next_st.fsm = S_IDLE;
      end
    endcase
    // uart: queued byte goes out at once
    if (next_st.q_full && emit_now(spi_mode, 1'b0))
    begin
      next_st.tx_valid = 1'b1;
      next_st.tx_data = next_st.q_byte;
      next_st.q_full = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st <= '0;
      st.fsm <= S_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign tx_valid = st.tx_valid;
  assign tx_data = st.tx_data;
  assign sensing_halt = st.halt;
  assign cal_all_start = st.cal_all;
  assign cal_key_start = st.cal_key;
  assign cal_key_idx = st.key_idx;
  assign cfg_wr = st.cfg_wr;
  assign cfg_wr_data = st.cfg_data;
  assign crc_clear = st.crc_clear;
  assign eeprom_commit = st.commit;
  assign eeprom_mark_invalid = st.mark_inv;
  assign flash_restore = st.restore;
  assign comm_error = st.err;

  // key recal strobe follows its reply by one cycle in uart mode
  sequence key_reply_s;
    st.fsm == S_CAL_WAIT && !st.cal_pending_all;
  endsequence
  key_reply_a: assert property (@(posedge clk_sys) disable iff (srst)
    key_reply_s |-> (spi_mode || (tx_valid && tx_data == ~{CMD_CAL_KEY_HI, cal_key_idx}))
      ##1 cal_key_start)
    else $error("key recal did not follow its reply");
  key_idx_a: assert property (@(posedge clk_sys) disable iff (srst)
    cal_key_start |-> cal_key_idx <= KEY_MAX)
    else $error("key index out of range");
  last_cmd_a: assert property (@(posedge clk_sys) disable iff (srst)
    (rx_valid && rx_data == CMD_LAST && st.fsm == S_IDLE && !spi_mode)
      |=> (tx_valid && tx_data == ~$past(st.last_cmd)))
    else $error("last command reply wrong");
  err_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (rx_valid && rx_data == CMD_LAST && st.fsm == S_IDLE) |=> !comm_error)
    else $error("error flag not cleared");
  halt_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st.fsm == S_CFG_DATA) |-> sensing_halt)
    else $error("sensing not halted in config load");
  nak_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st.fsm == S_CFG_BURN && eeprom_done && st.crc_bad) |=> eeprom_mark_invalid)
    else $error("bad crc not marked invalid");
  single_a: assert property (@(posedge clk_sys) disable iff (srst)
    cal_key_start |-> $past(st.fsm) == S_CAL_WAIT && $past(st.fsm, 2) == S_ARMED)
    else $error("recal without double send");
  commit_a: assert property (@(posedge clk_sys) disable iff (srst)
    eeprom_commit |-> st.fsm == S_CFG_BURN)
    else $error("commit outside burn");
endmodule

/* File: bench/tkc_host.sv */
module tkc_host
  import tkc_pkg::*;
(
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_rep = 0;
  logic [7:0] last_rep = 8'h00;
  // idle line at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // collect reply bytes
  always @(posedge clk_sys)
    if (tx_valid === 1'b1)
    begin
      n_rep <= n_rep + 1;
      last_rep <= tx_data;
    end
  // one byte per strobe; released line shows the inverse
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  // two adjacent copies, nothing between
  task automatic send2(input logic [7:0] b);
    send(b);
    send(b);
  endtask
  // one null byte per pending reply byte
  task automatic pull();
    send(CMD_NULL);
  endtask
  // 16-bit fields go low byte first
  task automatic send16(input logic [15:0] w);
    send(w[7:0]);
    send(w[15:8]);
  endtask
  // repeat the last-command query, up to 3 times, until a reply comes
  task automatic resync();
    int n0;
    for (int i = 0; i < 3; i++)
    begin
      n0 = n_rep;
      send(CMD_LAST);
      repeat (3) @(posedge clk_sys);
      if (n_rep != n0)
        break;
    end
  endtask
endmodule

/* File: bench/touch_key_command_handler_tb.sv */
module touch_key_command_handler_tb
  import tkc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 50;
  localparam int NCFG = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic spi_mode = 1'b0;
  logic [15:0] crc_calc = 16'h1234;
  logic cal_started = 1'b0;
  logic eeprom_done = 1'b0;
  logic eeprom_invalid_in = 1'b0;
  logic rx_valid, tx_valid, sensing_halt, cal_all_start, cal_key_start, cfg_wr;
  logic eeprom_commit, eeprom_mark_invalid, flash_restore, comm_error, crc_clear;
  logic [7:0] rx_data, tx_data, cfg_wr_data;
  logic [5:0] cal_key_idx;
  logic [5:0] key_seen = 6'h00;
  logic [7:0] wr_seen = 8'h00;
  int fail_count = 0;
  int total_checks = 0;
  int n_key = 0, n_all = 0, n_wr = 0, n_com = 0, n_inv = 0, n_fr = 0, n_clr = 0;

  tkc_cmd #(.WINDOW_CYCLES(WIN), .CFG_LEN(NCFG)) dut (
    .clk_sys(clk_sys), .srst(srst), .spi_mode(spi_mode), .rx_valid(rx_valid),
    .rx_data(rx_data), .crc_calc(crc_calc), .cal_started(cal_started),
    .eeprom_done(eeprom_done), .eeprom_invalid_in(eeprom_invalid_in),
    .tx_valid(tx_valid), .tx_data(tx_data), .sensing_halt(sensing_halt),
    .cal_all_start(cal_all_start), .cal_key_start(cal_key_start),
    .cal_key_idx(cal_key_idx), .cfg_wr(cfg_wr), .cfg_wr_data(cfg_wr_data),
    .crc_clear(crc_clear), .eeprom_commit(eeprom_commit),
    .eeprom_mark_invalid(eeprom_mark_invalid), .flash_restore(flash_restore),
    .comm_error(comm_error));

  tkc_host host (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data));

  // 250 MHz clock
  initial
    forever #2 clk_sys = ~clk_sys;

  // count strobes from the design
  always @(posedge clk_sys)
  begin
    n_key <= n_key + int'(cal_key_start === 1'b1);
    n_all <= n_all + int'(cal_all_start === 1'b1);
    n_wr <= n_wr + int'(cfg_wr === 1'b1);
    n_com <= n_com + int'(eeprom_commit === 1'b1);
    n_inv <= n_inv + int'(eeprom_mark_invalid === 1'b1);
    n_fr <= n_fr + int'(flash_restore === 1'b1);
    n_clr <= n_clr + int'(crc_clear === 1'b1);
    if (cal_key_start === 1'b1)
      key_seen <= cal_key_idx;
    if (cfg_wr === 1'b1)
      wr_seen <= cfg_wr_data;
  end

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask

  // reset pulse with a chosen invalid mark
  task automatic do_reset(input logic inv);
    @(posedge clk_sys);
    srst <= 1'b1;
    eeprom_invalid_in <= inv;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    settle();
  endtask

  // flash restore only with an invalid mark
  task automatic t_reset();
    int f0;
    f0 = n_fr;
    do_reset(1'b1);
    check(16'(n_fr - f0), 16'h1);
    do_reset(1'b0);
    check(16'(n_fr - f0), 16'h1);
    check({sensing_halt, comm_error, tx_valid}, 16'h0);
    $display("reset test done");
  endtask

  // key recal at index 5 and index 47, then index 48 refused
  task automatic t_key();
    logic [7:0] c [2] = '{8'hc5, 8'hef};
    int r0;
    int k0;
    foreach (c[i])
    begin
      r0 = host.n_rep;
      k0 = n_key;
      host.send2(c[i]);
      repeat (4) @(posedge clk_sys);
      check(16'(host.n_rep - r0), 16'h1);
      check(host.last_rep, 8'(~c[i]));
      check(16'(n_key - k0), 16'h1);
      check(sensing_halt, 1'b0);
      check(key_seen, c[i][5:0]);
    end
    r0 = host.n_rep;
    host.send2(8'hf0);
    settle();
    check(16'(host.n_rep - r0 + n_key - k0), 16'h1);
    check(comm_error, 1'b1);
    host.send(CMD_LAST);
    settle();
    check(host.last_rep, 8'h0f);
    check(comm_error, 1'b0);
    host.send(CMD_LAST);
    settle();
    check(host.last_rep, 8'(~CMD_LAST));
    $display("key test done");
  endtask

  // copy broken by another byte, and a lone copy left to expire
  task automatic t_cancel();
    int r0;
    int k0;
    r0 = host.n_rep;
    k0 = n_key;
    host.send(8'hc5);
    host.resync();
    check(host.last_rep, 8'h3a);
    host.send(8'hc5);
    repeat (WIN + 10) @(posedge clk_sys);
    host.send(8'hc5);
    repeat (WIN + 10) @(posedge clk_sys);
    check(16'(host.n_rep - r0), 16'h1);
    check(16'(n_key - k0), 16'h0);
    $display("cancel test done");
  endtask

  // cal all replies only once calibration has begun
  task automatic t_cal_all();
    int r0;
    int a0;
    r0 = host.n_rep;
    a0 = n_all;
    host.send2(CMD_CAL_ALL);
    for (int i = 0; i < 10 && n_all == a0; i++)
      @(posedge clk_sys);
    check(16'(n_all - a0), 16'h1);
    check(16'(host.n_rep - r0), 16'h0);
    cal_started <= 1'b1;
    @(posedge clk_sys);
    cal_started <= 1'b0;
    settle();
    check(host.last_rep, 8'(~CMD_CAL_ALL));
    $display("cal all test done");
  endtask

  // config load with good, bad and zero block check values
  task automatic t_cfg();
    logic [15:0] crc [3] = '{16'h1234, 16'h1235, 16'h0000};
    logic [7:0] fin [3] = '{ACK_BYTE, NAK_BYTE, ACK_BYTE};
    int r0;
    int c0;
    int w0;
    int v0;
    int l0;
    foreach (crc[i])
    begin
      r0 = host.n_rep;
      c0 = n_com;
      w0 = n_wr;
      v0 = n_inv;
      l0 = n_clr;
      host.send2(CMD_SETUP);
      settle();
      check(host.last_rep, ACK_BYTE);
      check(16'(n_clr - l0), 16'h1);
      check(sensing_halt, 1'b1);
      for (int j = 0; j < NCFG; j++)
        host.send(8'(8'ha0 + j));
      host.send16(crc[i]);
      for (int k = 0; k < 20 && n_com == c0; k++)
        @(posedge clk_sys);
      check(16'(n_wr - w0), 16'(NCFG));
      check(wr_seen, 8'(8'ha0 + NCFG - 1));
      check(16'(n_com - c0), 16'h1);
      eeprom_done <= 1'b1;
      @(posedge clk_sys);
      eeprom_done <= 1'b0;
      settle();
      check(16'(host.n_rep - r0), 16'h2);
      check(host.last_rep, fin[i]);
      check(16'(n_inv - v0), 16'(i == 1));
      check(sensing_halt, 1'b0);
    end
    $display("config test done");
  endtask

  // stalled load and lone entry copy go quiet
  task automatic t_abandon();
    int r0;
    r0 = host.n_rep;
    host.send2(CMD_SETUP);
    host.send(8'h55);
    repeat (WIN + 10) @(posedge clk_sys);
    check(sensing_halt, 1'b0);
    host.send(CMD_SETUP);
    repeat (WIN + 10) @(posedge clk_sys);
    check(16'(host.n_rep - r0), 16'h1);
    check(sensing_halt, 1'b0);
    $display("abandon test done");
  endtask

  // spi replies wait for null bytes
  task automatic t_spi();
    int r0;
    spi_mode <= 1'b1;
    r0 = host.n_rep;
    host.send(CMD_LAST);
    settle();
    check(16'(host.n_rep - r0), 16'h0);
    host.pull();
    settle();
    check(host.last_rep, 8'(~CMD_SETUP));
    host.pull();
    settle();
    check(16'(host.n_rep - r0), 16'h2);
    check(host.last_rep, NAK_BYTE);
    $display("spi test done");
  endtask

  // hang guard
  initial
  begin
    #400000;
    fail_count++;
    final_report();
  end

  // main sequence
  initial
  begin
    do_reset(1'b0);
    t_reset();
    t_key();
    t_cancel();
    t_cal_all();
    t_cfg();
    t_abandon();
    t_spi();
    final_report();
  end
endmodule
